// ### rtl/cbx_defines.vh
`ifndef CBX_DEFINES_VH
`define CBX_DEFINES_VH
// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define CBX_OFF_CTRL 12'h000
`define CBX_OFF_INSTR 12'h004
`define CBX_OFF_OPER 12'h008
`define CBX_OFF_RESULT 12'h00C
`define CBX_OFF_FLAGS 12'h010
`define CBX_OFF_STATUS 12'h014
`define CBX_OFF_IODATA 12'h018
`define CBX_OFF_DBG 12'h01C
// ----------------------------------------
// Status flag bit positions
// ----------------------------------------
`define CBX_F_C 0
`define CBX_F_Z 1
`define CBX_F_N 2
`define CBX_F_V 3
`define CBX_F_S 4
`define CBX_F_H 5
`define CBX_F_T 6
`define CBX_F_I 7
// ----------------------------------------
// Operation codes
// ----------------------------------------
`define CBX_OP_IDLE 5'h00
`define CBX_OP_IN 5'h01
`define CBX_OP_OUT 5'h02
`define CBX_OP_PUSH 5'h03
`define CBX_OP_POP 5'h04
`define CBX_OP_ROTL 5'h05
`define CBX_OP_ROTR 5'h06
`define CBX_OP_LSLU 5'h07
`define CBX_OP_LSRD 5'h08
`define CBX_OP_ASRD 5'h09
`define CBX_OP_SWAPN 5'h0A
`define CBX_OP_IOSET 5'h0B
`define CBX_OP_IOCLR 5'h0C
`define CBX_OP_TSTORE 5'h0D
`define CBX_OP_TLOAD 5'h0E
`define CBX_OP_FSET 5'h0F
`define CBX_OP_FCLR 5'h10
`define CBX_OP_BRK 5'h11
`define CBX_OP_SLP 5'h12
`define CBX_OP_WDOG 5'h13
// ----------------------------------------
// Cycle counts and penalties
// ----------------------------------------
`define CBX_CYC_ONE 3'h1
`define CBX_CYC_TWO 3'h2
`define CBX_NVM_EXTRA 3'h1
`define CBX_LOW_IO_LIMIT 6'h3F
`define CBX_STACK_TOP 8'hFF
`endif

// ### rtl/cbx_mem.v
`timescale 1ns/1ns
module cbx_mem #(
  parameter AW = 8,
  parameter DW = 8
) (
  input wire clk, // clock
  input wire we, // write strobe
  input wire [AW-1:0] waddr, // write address
  input wire [DW-1:0] wdata, // write data
  input wire [AW-1:0] raddr, // read address
  output reg [DW-1:0] rdata // registered read data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ### rtl/cbx_alu.v
`timescale 1ns/1ns
`include "cbx_defines.vh"
module cbx_alu (
  input wire [4:0] op, // operation
  input wire [7:0] din, // operand
  input wire [7:0] flags_in, // current flags
  input wire [2:0] bsel, // bit select
  output reg [7:0] dout, // result
  output reg [7:0] flags_out // next flags
);
  reg c;
  always @* begin
    dout = din;
    flags_out = flags_in;
    c = flags_in[`CBX_F_C];
    case (op)
      `CBX_OP_ROTL: begin
        dout = {din[6:0], c}; // see RQ4
        c = din[7];
      end
      `CBX_OP_ROTR: begin
        dout = {c, din[7:1]}; // see RQ5
        c = din[0];
      end
      `CBX_OP_LSLU: begin
        dout = {din[6:0], 1'b0}; // see RQ18
        c = din[7];
      end
      `CBX_OP_LSRD: begin
        dout = {1'b0, din[7:1]}; // see RQ18
        c = din[0];
      end
      `CBX_OP_ASRD: begin
        dout = {din[7], din[7:1]}; // see RQ18
        c = din[0];
      end
      `CBX_OP_SWAPN: dout = {din[3:0], din[7:4]}; // see RQ18
      `CBX_OP_TSTORE: flags_out[`CBX_F_T] = din[bsel]; // see RQ8
      `CBX_OP_TLOAD: dout[bsel] = flags_in[`CBX_F_T]; // see RQ9
      `CBX_OP_FSET: flags_out[bsel] = 1'b1; // see RQ10 RQ11 RQ12 RQ19
      `CBX_OP_FCLR: flags_out[bsel] = 1'b0; // see RQ10 RQ11 RQ12 RQ19
      default: dout = din;
    endcase
    if (op == `CBX_OP_ROTL || op == `CBX_OP_ROTR || op == `CBX_OP_LSLU ||
        op == `CBX_OP_LSRD || op == `CBX_OP_ASRD) begin
      flags_out[`CBX_F_C] = c;
      flags_out[`CBX_F_Z] = (dout == 8'h00);
      flags_out[`CBX_F_N] = dout[7];
      flags_out[`CBX_F_V] = dout[7] ^ c;
      flags_out[`CBX_F_S] = dout[7] ^ (dout[7] ^ c);
      if (op == `CBX_OP_ROTL || op == `CBX_OP_LSLU) begin
        flags_out[`CBX_F_H] = din[3]; // see RQ4
      end
    end
  end
endmodule

// ### rtl/cbx_core.v
`timescale 1ns/1ns
`include "cbx_defines.vh"
// Functional notes
// RQ1 - IN/OUT move a byte between I/O and register in one cycle, no flags.
// RQ2 - Push writes register to stack in two cycles, flags untouched.
// RQ3 - Pop loads register from stack in two cycles, flags untouched.
// RQ4 - Rotate left through carry updates Z,C,N,V,H in one cycle.
// RQ5 - Rotate right through carry updates Z,C,N,V in one cycle.
// RQ6 - I/O bit set forces selected bit to one in two cycles.
// RQ7 - I/O bit clear forces selected bit to zero in two cycles.
// RQ8 - Bit store copies register bit into transfer flag, one cycle.
// RQ9 - Bit load copies transfer flag into register bit, one cycle.
// RQ10 - Overflow flag set/clear in one cycle, nothing else changes.
// RQ11 - Half-carry flag set/clear in one cycle, nothing else changes.
// RQ12 - Signed flag set/clear in one cycle, nothing else changes.
// RQ13 - Sleep takes one cycle and signals power management.
// RQ14 - Break takes one cycle and signals debug logic.
// RQ15 - Watchdog restart takes one cycle and pulses watchdog restart.
// RQ16 - Accesses through the NVM controller add one cycle or more.
// RQ17 - Stores to the lowest 64 I/O bytes take one extra cycle.
// RQ18 - Shifts fill with zero or sign; swap exchanges nibbles; one cycle.
// RQ19 - Carry, negative, zero, transfer, interrupt flag set/clear alter only that flag.
// RQ20 - No-operation takes one cycle and changes nothing.
module cbx_core (
  input wire hclk, // clock
  input wire hresetn, // async reset, active low
  input wire hsel, // slave select
  input wire [31:0] haddr, // address
  input wire [1:0] htrans, // transfer type
  input wire hwrite, // write
  input wire [2:0] hsize, // size
  input wire [31:0] hwdata, // write data
  input wire hready, // bus ready
  output wire hreadyout, // slave ready
  output wire hresp, // response, always OKAY
  output reg [31:0] hrdata, // read data
  input wire nvm_wait, // NVM controller contention
  output reg sleep_req, // sleep pulse
  output reg break_req, // break pulse
  output reg wdog_restart // watchdog restart pulse
);
  // ----------------------------------------
  // Bus capture
  // ----------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_EXEC = 3'b010;
  localparam ST_DONE = 3'b100;
  reg wr_q;
  reg rd_q;
  reg [11:0] addr_q;
  reg [2:0] state_q;
  reg [2:0] cnt_q;
  reg [4:0] op_q;
  reg [7:0] oper_q;
  reg [2:0] bsel_q;
  reg nvm_q;
  reg [7:0] wreg_q;
  reg [7:0] iodata_q;
  reg [5:0] ioaddr_q;
  reg [7:0] flags_q;
  reg [7:0] sp_q;
  reg [7:0] result_q;
  reg [7:0] dbg_q;
  reg busy_q;
  wire accept = hsel & hready & htrans[1];
  wire [7:0] alu_dout;
  wire [7:0] alu_flags;
  wire [7:0] stk_rdata;
  wire stk_we;
  wire [7:0] stk_addr_w;
  reg [2:0] need;
  // Writes to the instruction register start execution.
  wire start = wr_q & (addr_q == `CBX_OFF_INSTR) & ~busy_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 12'h000;
    end else begin
      wr_q <= accept & hwrite;
      rd_q <= accept & ~hwrite;
      if (accept) begin
        addr_q <= haddr[11:0];
      end
    end
  end
  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  cbx_alu u_alu (
    .op(op_q),
    .din(wreg_q),
    .flags_in(flags_q),
    .bsel(bsel_q),
    .dout(alu_dout),
    .flags_out(alu_flags)
  );
  assign stk_we = busy_q & (op_q == `CBX_OP_PUSH) & (cnt_q == `CBX_CYC_ONE);
  assign stk_addr_w = sp_q;
  cbx_mem #(.AW(8), .DW(8)) u_stack (
    .clk(hclk),
    .we(stk_we),
    .waddr(stk_addr_w),
    .wdata(wreg_q),
    .raddr(sp_q + 8'h01),
    .rdata(stk_rdata)
  );
  // ----------------------------------------
  // Cycle budget per operation
  // ----------------------------------------
  always @* begin
    need = `CBX_CYC_ONE; // see RQ1 RQ13 RQ14 RQ15 RQ20
    if (op_q == `CBX_OP_PUSH || op_q == `CBX_OP_POP) begin
      need = `CBX_CYC_TWO; // see RQ2 RQ3
    end else if (op_q == `CBX_OP_IOSET || op_q == `CBX_OP_IOCLR) begin
      need = `CBX_CYC_TWO; // see RQ6 RQ7
    end
    // Low I/O stores pay one extra cycle.
    if (op_q == `CBX_OP_OUT && ioaddr_q <= `CBX_LOW_IO_LIMIT) begin
      need = need + `CBX_CYC_ONE; // see RQ17
    end
    if (nvm_q) begin
      need = need + `CBX_NVM_EXTRA; // see RQ16
    end
  end
  // ----------------------------------------
  // Execution sequencer
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      cnt_q <= 3'h0;
      busy_q <= 1'b0;
      op_q <= `CBX_OP_IDLE;
      oper_q <= 8'h00;
      bsel_q <= 3'h0;
      nvm_q <= 1'b0;
      wreg_q <= 8'h00;
      iodata_q <= 8'h00;
      ioaddr_q <= 6'h00;
      flags_q <= 8'h00;
      sp_q <= `CBX_STACK_TOP;
      result_q <= 8'h00;
      dbg_q <= 8'h00;
      sleep_req <= 1'b0;
      break_req <= 1'b0;
      wdog_restart <= 1'b0;
    end else begin
      sleep_req <= 1'b0;
      break_req <= 1'b0;
      wdog_restart <= 1'b0;
      if (wr_q && !busy_q) begin
        if (addr_q == `CBX_OFF_OPER) begin
          wreg_q <= hwdata[7:0];
          ioaddr_q <= hwdata[13:8];
          bsel_q <= hwdata[18:16];
          nvm_q <= hwdata[24];
        end else if (addr_q == `CBX_OFF_FLAGS) begin
          flags_q <= hwdata[7:0];
        end else if (addr_q == `CBX_OFF_IODATA) begin
          iodata_q <= hwdata[7:0];
        end
      end
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            op_q <= hwdata[4:0];
            busy_q <= 1'b1;
            cnt_q <= `CBX_CYC_ONE;
            state_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (cnt_q >= need && !(nvm_q && nvm_wait)) begin
            state_q <= ST_DONE;
            busy_q <= 1'b0;
            case (op_q)
              `CBX_OP_IN: wreg_q <= iodata_q; // see RQ1
              `CBX_OP_OUT: iodata_q <= wreg_q; // see RQ1
              `CBX_OP_PUSH: sp_q <= sp_q - 8'h01; // see RQ2
              `CBX_OP_POP: begin
                wreg_q <= stk_rdata; // see RQ3
                sp_q <= sp_q + 8'h01;
              end
              `CBX_OP_IOSET: iodata_q[bsel_q] <= 1'b1; // see RQ6
              `CBX_OP_IOCLR: iodata_q[bsel_q] <= 1'b0; // see RQ7
              `CBX_OP_SLP: sleep_req <= 1'b1; // see RQ13
              `CBX_OP_BRK: begin
                break_req <= 1'b1; // see RQ14
                dbg_q <= dbg_q + 8'h01;
              end
              `CBX_OP_WDOG: wdog_restart <= 1'b1; // see RQ15
              `CBX_OP_IDLE: wreg_q <= wreg_q; // see RQ20
              default: begin
                wreg_q <= alu_dout;
                flags_q <= alu_flags;
              end
            endcase
            result_q <= {3'h0, op_q};
          end else if (cnt_q < need) begin
            // Saturate so a long stall cannot wrap the count
            cnt_q <= cnt_q + `CBX_CYC_ONE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (accept && !hwrite) begin
      if (haddr[11:0] == `CBX_OFF_CTRL) begin
        hrdata <= {29'h0, state_q};
      end else if (haddr[11:0] == `CBX_OFF_OPER) begin
        hrdata <= {7'h0, nvm_q, 5'h0, bsel_q, 2'h0, ioaddr_q, wreg_q};
      end else if (haddr[11:0] == `CBX_OFF_RESULT) begin
        hrdata <= {24'h0, result_q};
      end else if (haddr[11:0] == `CBX_OFF_FLAGS) begin
        hrdata <= {24'h0, flags_q};
      end else if (haddr[11:0] == `CBX_OFF_STATUS) begin
        hrdata <= {16'h0, sp_q, 7'h0, busy_q};
      end else if (haddr[11:0] == `CBX_OFF_IODATA) begin
        hrdata <= {24'h0, iodata_q};
      end else if (haddr[11:0] == `CBX_OFF_DBG) begin
        hrdata <= {24'h0, dbg_q};
      end else begin
        hrdata <= 32'h00000000;
      end
    end
  end
endmodule

// ### testbench/cbx_core_sva.sv
`timescale 1ns/1ns
`include "cbx_defines.vh"
module cbx_core_sva (
  input wire hclk, // clock
  input wire hresetn, // reset, active low
  input wire hsel, // select
  input wire [31:0] haddr, // address
  input wire [1:0] htrans, // transfer type
  input wire hwrite, // write
  input wire [31:0] hwdata, // write data
  input wire hready, // bus ready
  input wire hreadyout, // slave ready
  input wire hresp, // response
  input wire [31:0] hrdata, // read data
  input wire sleep_req, // sleep pulse
  input wire break_req, // break pulse
  input wire wdog_restart // watchdog pulse
);
  reg iw_q;
  reg nvm_q;
  reg ow_q;
  wire aw = hsel && htrans[1] && hready && hwrite;
  wire ar = hsel && htrans[1] && hready && !hwrite;
  wire [4:0] op = hwdata[4:0];
  // ----
  // Data phase of instruction and operand writes
  // ----
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      iw_q <= 1'b0;
      ow_q <= 1'b0;
      nvm_q <= 1'b0;
    end else begin
      iw_q <= aw && haddr[11:0] == `CBX_OFF_INSTR;
      ow_q <= aw && haddr[11:0] == `CBX_OFF_OPER;
      if (ow_q) nvm_q <= hwdata[24];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // NVM accesses excluded, a stall makes their latency open ended
  AST_SLP_LAT: assert property (iw_q && op == `CBX_OP_SLP && !nvm_q |-> ##[1:4] sleep_req)
    else $error("sleep pulse missing");
  AST_BRK_LAT: assert property (iw_q && op == `CBX_OP_BRK && !nvm_q |-> ##[1:4] break_req)
    else $error("break pulse missing");
  AST_WDOG_LAT: assert property (iw_q && op == `CBX_OP_WDOG && !nvm_q |-> ##[1:4] wdog_restart)
    else $error("watchdog pulse missing");
  AST_SLP_ONE: assert property (sleep_req |=> !sleep_req)
    else $error("sleep pulse too long");
  AST_BRK_ONE: assert property (break_req |=> !break_req)
    else $error("break pulse too long");
  AST_WDOG_ONE: assert property (wdog_restart |=> !wdog_restart)
    else $error("watchdog pulse too long");
  AST_EXCL: assert property (sleep_req |-> !break_req && !wdog_restart)
    else $error("pulses overlap");
  AST_RD_HOLD: assert property (!ar |=> $stable(hrdata))
    else $error("read data moved");
  AST_BUS_OK: assert property (hreadyout && !hresp)
    else $error("bus not ready or error");
endmodule
bind cbx_core cbx_core_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sleep_req(sleep_req),
  .break_req(break_req), .wdog_restart(wdog_restart));

// ### testbench/cbx_nvm_model.sv
`timescale 1ns/1ns
module cbx_nvm_model (
  input wire hclk, // clock
  input wire hresetn, // reset, active low
  input wire start, // begin contention
  input wire [3:0] len, // contention cycles
  output wire nvm_wait // controller busy
);
  reg [3:0] cnt_q;
  // Other masters hold the controller for len cycles
  assign nvm_wait = cnt_q != 4'h0;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt_q <= 4'h0;
    else if (start) cnt_q <= len;
    else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
  end
endmodule

// ### testbench/testbench.sv
`timescale 1ns/1ns
`include "cbx_defines.vh"
module testbench;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [2:0] hsize = 3'h0;
  reg [31:0] hwdata = 32'h0;
  reg ns_go = 1'b0;
  reg [3:0] ns_len = 4'h0;
  wire hreadyout, hresp, nvm_wait, sleep_req, break_req, wdog_restart;
  wire [31:0] hrdata;
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;
  int t_iss, t_pul, base, k;
  reg [63:0] eq[$];
  reg [2:0] pq[$];
  reg rd_dph = 1'b0;
  reg [7:0] fl, d, d2;
  reg [2:0] b;
  reg [15:0] x;
  reg [31:0] rv, rn;
  reg [4:0] ops [0:7];
  always #25 hclk = ~hclk;
  cbx_core u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .nvm_wait(nvm_wait),
    .sleep_req(sleep_req), .break_req(break_req), .wdog_restart(wdog_restart));
  cbx_nvm_model u_nvm (.hclk(hclk), .hresetn(hresetn), .start(ns_go), .len(ns_len),
    .nvm_wait(nvm_wait));
  // ----
  // Checking
  // ----
  task cmp_data(input [31:0] got, input [31:0] exp, input [31:0] m);
    compares++;
    if ((got & m) !== (exp & m)) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got & m, exp & m);
    end
  endtask
  task cmp_pulse(input [2:0] got, input [2:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t pulse got %h exp %h", $time, got, exp);
    end
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (rd_dph && hreadyout === 1'b1 && eq.size() > 0) begin
      if (eq[0][63:32] != 32'h0) cmp_data(hrdata, eq[0][31:0], eq[0][63:32]);
      void'(eq.pop_front());
    end
    if (hreadyout === 1'b1) rd_dph <= hsel && htrans[1] && !hwrite;
    if (sleep_req | break_req | wdog_restart) begin
      t_pul = cyc;
      cmp_pulse({wdog_restart, break_req, sleep_req},
        pq.size() ? pq.pop_front() : 3'h0);
    end
  end
  function [15:0] alu(input [4:0] op, input [7:0] v, input [7:0] f, input [2:0] s);
    reg [7:0] r;
    reg [7:0] n;
    r = v;
    n = f;
    case (op)
      `CBX_OP_ROTL: begin r = {v[6:0], f[0]}; n[0] = v[7]; n[5] = v[3]; end
      `CBX_OP_ROTR: begin r = {f[0], v[7:1]}; n[0] = v[0]; end
      `CBX_OP_LSLU: begin r = {v[6:0], 1'b0}; n[0] = v[7]; n[5] = v[3]; end
      `CBX_OP_LSRD: begin r = {1'b0, v[7:1]}; n[0] = v[0]; end
      `CBX_OP_ASRD: begin r = {v[7], v[7:1]}; n[0] = v[0]; end
      `CBX_OP_SWAPN: r = {v[3:0], v[7:4]};
      `CBX_OP_TLOAD: r[s] = f[6];
      default: n[6] = v[s];
    endcase
    if (op < `CBX_OP_SWAPN) begin
      n[1] = r == 8'h00;
      n[2] = r[7];
      n[3] = n[2] ^ n[0];
      n[4] = n[2] ^ n[3];
    end
    alu = {n, r};
  endfunction
  // ----
  // Bus driving
  // ----
  task ahb(input w, input [11:0] a, input [31:0] dat);
    int i;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge hclk);
    for (i = 0; i < 50 && hreadyout !== 1'b1; i++) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= dat;
    @(posedge hclk);
    for (i = 0; i < 50 && hreadyout !== 1'b1; i++) @(posedge hclk);
    rv = hrdata;
  endtask
  task rd(input [11:0] a, input [31:0] e, input [31:0] m);
    eq.push_back({m, e});
    ahb(1'b0, a, 32'h0);
  endtask
  task run(input [4:0] op, input [7:0] w, input [2:0] s, input nv, input [5:0] io);
    int i;
    ahb(1'b1, `CBX_OFF_OPER, {7'h0, nv, 5'h0, s, 2'h0, io, w});
    ahb(1'b1, `CBX_OFF_INSTR, {27'h0, op});
    t_iss = cyc;
    @(posedge hclk);
    for (i = 0; i < 40; i++) begin
      rd(`CBX_OFF_STATUS, 32'h0, 32'h0);
      if (rv[0] === 1'b0) break;
    end
  endtask
  task tally_and_finish;
    $display("Counts: %0d compares, %0d miscompares", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    tally_and_finish;
  end
  initial begin
    ops = '{`CBX_OP_ROTL, `CBX_OP_ROTR, `CBX_OP_LSLU, `CBX_OP_LSRD, `CBX_OP_ASRD,
      `CBX_OP_SWAPN, `CBX_OP_TSTORE, `CBX_OP_TLOAD};
    void'($urandom(32'h75ec81ae));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`CBX_OFF_FLAGS, 32'h0, 32'hFF);
    rd(`CBX_OFF_STATUS, 32'hFF00, 32'hFF01);
    rd(12'h040, 32'h0, 32'hFFFFFFFF);
    fl = 8'h00;
    // Set all flags one by one, then clear them, others must hold
    for (k = 0; k < 16; k++) begin
      run(k < 8 ? `CBX_OP_FSET : `CBX_OP_FCLR, 8'h00, k[2:0], 1'b0, 6'h10);
      fl[k[2:0]] = k < 8;
      rd(`CBX_OFF_FLAGS, {24'h0, fl}, 32'hFF);
    end
    for (k = 0; k < 24; k++) begin
      rn = $urandom;
      d = k == 0 ? 8'h80 : rn[7:0];
      x = alu(ops[k % 8], d, fl, rn[10:8]);
      run(ops[k % 8], d, rn[10:8], 1'b0, 6'h10);
      rd(`CBX_OFF_OPER, x[7:0], 32'hFF);
      fl = x[15:8];
      rd(`CBX_OFF_FLAGS, {24'h0, fl}, 32'hFF);
    end
    rn = $urandom;
    d = rn[7:0];
    d2 = rn[15:8];
    b = rn[18:16];
    run(`CBX_OP_PUSH, d, 3'h0, 1'b0, 6'h10);
    run(`CBX_OP_PUSH, d2, 3'h0, 1'b0, 6'h10);
    run(`CBX_OP_POP, 8'h00, 3'h0, 1'b0, 6'h10);
    rd(`CBX_OFF_OPER, d2, 32'hFF);
    run(`CBX_OP_POP, 8'h00, 3'h0, 1'b0, 6'h10);
    rd(`CBX_OFF_OPER, d, 32'hFF);
    rd(`CBX_OFF_STATUS, 32'hFF00, 32'hFF01);
    run(`CBX_OP_OUT, d, 3'h0, 1'b0, 6'h2A);
    run(`CBX_OP_IOSET, 8'h00, b, 1'b0, 6'h2A);
    run(`CBX_OP_IN, 8'h00, 3'h0, 1'b0, 6'h2A);
    rd(`CBX_OFF_OPER, d | (8'h01 << b), 32'hFF);
    run(`CBX_OP_IOCLR, 8'h00, b, 1'b0, 6'h2A);
    run(`CBX_OP_IN, 8'h00, 3'h0, 1'b0, 6'h2A);
    rd(`CBX_OFF_OPER, d & ~(8'h01 << b), 32'hFF);
    rd(`CBX_OFF_RESULT, {27'h0, `CBX_OP_IN}, 32'hFF);
    run(`CBX_OP_IDLE, 8'h00, 3'h0, 1'b0, 6'h10);
    rd(`CBX_OFF_FLAGS, {24'h0, fl}, 32'hFF);
    pq.push_back(3'h1);
    run(`CBX_OP_SLP, 8'h00, 3'h0, 1'b0, 6'h10);
    base = t_pul - t_iss;
    cmp_data(base, 32'h2, 32'hFF);
    pq.push_back(3'h2);
    run(`CBX_OP_BRK, 8'h00, 3'h0, 1'b0, 6'h10);
    cmp_data(t_pul - t_iss, base, 32'hFF);
    pq.push_back(3'h4);
    run(`CBX_OP_WDOG, 8'h00, 3'h0, 1'b0, 6'h10);
    cmp_data(t_pul - t_iss, base, 32'hFF);
    rd(`CBX_OFF_DBG, 32'h1, 32'hFF);
    rd(`CBX_OFF_FLAGS, {24'h0, fl}, 32'hFF);
    pq.push_back(3'h1);
    run(`CBX_OP_SLP, 8'h00, 3'h0, 1'b1, 6'h10);
    cmp_data(t_pul - t_iss, base + 1, 32'hFF);
    ns_len <= 4'hC;
    ns_go <= 1'b1;
    @(posedge hclk);
    ns_go <= 1'b0;
    pq.push_back(3'h1);
    run(`CBX_OP_SLP, 8'h00, 3'h0, 1'b1, 6'h10);
    cmp_data(t_pul - t_iss > base + 1, 32'h1, 32'h1);
    tally_and_finish;
  end
endmodule
